// [rtl/alu_ops_regs.vh]
/*
 Register offsets, field positions, reset values and operation
 codes of the rotate, subtract, logic and power-down unit.
 Assumes a 32-bit AXI4-Lite slave with byte addresses.
*/
`ifndef ALU_OPS_REGS_VH
`define ALU_OPS_REGS_VH

// Register byte offsets
`define OFS_CMD        10'h000
`define OFS_ACC        10'h004
`define OFS_STATUS     10'h008
`define OFS_WDOG       10'h00C
`define OFS_WAKE       10'h010
`define OFS_FILE_BASE  10'h200

// Command word fields
`define CMD_OP_MSB     3
`define CMD_OP_LSB     0
`define CMD_DEST_BIT   4
`define CMD_FADR_MSB   14
`define CMD_FADR_LSB   8
`define CMD_LIT_MSB    23
`define CMD_LIT_LSB    16

// Status register bit positions
`define ST_CARRY       0
`define ST_DIGIT       1
`define ST_ZERO        2
`define ST_PWRDN_N     3
`define ST_TMOUT_N     4
`define ST_ASLEEP      5

// Operation codes
`define OP_ROT_RIGHT   4'h0
`define OP_LIT_SUB     4'h1
`define OP_REG_SUB     4'h2
`define OP_REG_XOR     4'h3
`define OP_LIT_XOR     4'h4
`define OP_NIB_SWAP    4'h5
`define OP_POWERDOWN   4'h6

// Reset values
`define RST_ACC        8'h00
`define RST_FLAG_N     1'b1
`define RST_WDOG       8'h00

// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

// [rtl/alu_ops_core.v]
/*
 Accumulator execution unit for rotate right through carry,
 subtracts, exclusive ORs, nibble swap and the power-down
 instruction, with its file registers, status flags and a
 simple watchdog, all reached over an AXI4-Lite slave.
 Assumes one clock, synchronous active-high reset, and a master
 that keeps to AXI4-Lite valid/ready signalling.
*/
`timescale 1ns/1ps
`include "alu_ops_regs.vh"

module alu_ops_core #(
   parameter FILE_DEPTH = 128,            // File registers
   parameter PRE_WIDTH  = 8               // Watchdog prescaler width
) (
   input  wire        I_CORE_CLK,         // Core clock, 40 MHz
   input  wire        I_SYS_RST,          // Sync reset, active high
   input  wire [9:0]  I_AWADDR,           // Write address
   input  wire        I_AWVALID,          // Write address valid
   output wire        O_AWREADY,          // Write address ready
   input  wire [31:0] I_WDATA,            // Write data
   input  wire [3:0]  I_WSTRB,            // Write byte strobes
   input  wire        I_WVALID,           // Write data valid
   output wire        O_WREADY,           // Write data ready
   output reg  [1:0]  O_BRESP,            // Write response
   output reg         O_BVALID,           // Write response valid
   input  wire        I_BREADY,           // Write response ready
   input  wire [9:0]  I_ARADDR,           // Read address
   input  wire        I_ARVALID,          // Read address valid
   output wire        O_ARREADY,          // Read address ready
   output reg  [31:0] O_RDATA,            // Read data
   output reg  [1:0]  O_RRESP,            // Read response
   output reg         O_RVALID,           // Read data valid
   input  wire        I_RREADY,           // Read data ready
   output wire        O_OSC_RUN           // Oscillator running
);

   // One-hot execution states
   localparam [2:0] S_IDLE  = 3'b001;     // Waiting for command
   localparam [2:0] S_EXEC  = 3'b010;     // Executing command
   localparam [2:0] S_SLEEP = 3'b100;     // Oscillator halted

   // Architectural state
   reg  [7:0]           file_reg [0:FILE_DEPTH-1]; // File registers
   reg  [7:0]           acc;              // Accumulator
   reg                  carry_flag;       // Carry
   reg                  digit_carry_flag; // Digit carry
   reg                  zero_flag;        // Zero
   reg                  powerdown_flag_n; // Low after power-down
   reg                  timeout_flag_n;   // Low after time-out
   reg  [7:0]           watchdog_counter; // Watchdog count
   reg  [PRE_WIDTH-1:0] wdog_prescaler;   // Watchdog prescaler
   reg  [2:0]           state;            // Execution state
   reg  [31:0]          cmd;              // Last command word

   // Command fields
   wire [3:0]           op_code;          // Operation
   wire                 dest_reg;         // 1: back into register
   wire [6:0]           fadr;             // Register address
   wire [7:0]           literal;          // Immediate operand
   wire [7:0]           fval;             // Addressed register value

   // Bus decode
   wire                 wr_go;            // Write taken this cycle
   wire                 rd_go;            // Read taken this cycle
   wire                 wr_file;          // Write hits file window
   wire                 rd_file;          // Read hits file window
   wire [6:0]           wr_idx;           // File index of write
   wire [6:0]           rd_idx;           // File index of read
   wire                 wdog_tick;        // Prescaler wrap enable

   // Execution result
   reg  [7:0]           next_res;         // Result byte
   reg                  next_c;           // New carry
   reg                  next_digit;       // New digit carry
   reg                  upd_c;            // Carry is updated
   reg                  upd_digit;        // Digit carry is updated
   reg                  upd_z;            // Zero is updated
   reg                  writes;           // Result is written
   reg                  to_reg;           // Result goes to register
   reg  [8:0]           diff;             // Full subtract
   reg  [4:0]           ndiff;            // Low nibble subtract
   reg  [7:0]           minuend;          // Left operand of subtract

   assign op_code  = cmd[`CMD_OP_MSB:`CMD_OP_LSB];
   assign dest_reg = cmd[`CMD_DEST_BIT];
   assign fadr     = cmd[`CMD_FADR_MSB:`CMD_FADR_LSB];
   assign literal  = cmd[`CMD_LIT_MSB:`CMD_LIT_LSB];
   assign fval     = file_reg[fadr];

   // Write side takes address and data together, never mid-exec
   assign wr_go     = I_AWVALID & I_WVALID & ~O_BVALID
                      & (state != S_EXEC);
   assign O_AWREADY = wr_go;
   assign O_WREADY  = wr_go;
   assign rd_go     = I_ARVALID & ~O_RVALID;
   assign O_ARREADY = rd_go;

   // File window decode
   assign wr_file = (I_AWADDR[9] == 1'b1);
   assign rd_file = (I_ARADDR[9] == 1'b1);
   assign wr_idx  = I_AWADDR[8:2];
   assign rd_idx  = I_ARADDR[8:2];

   // Oscillator stops while asleep
   assign O_OSC_RUN = (state != S_SLEEP);

   // Prescaler wraps to advance the watchdog
   assign wdog_tick = &wdog_prescaler;

   // Combinational result of the current command
   always @* begin
      next_res = acc;
      next_c   = carry_flag;
      next_digit = digit_carry_flag;
      upd_c    = 1'b0;
      upd_digit = 1'b0;
      upd_z    = 1'b0;
      writes   = 1'b0;
      to_reg   = 1'b0;
      minuend  = (op_code == `OP_LIT_SUB) ? literal : fval;
      diff     = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
      ndiff    = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      case (op_code)
         `OP_ROT_RIGHT: begin
            // Old carry in at top, bit 0 out to carry
            next_res = {carry_flag, fval[7:1]};
            next_c   = fval[0];
            upd_c    = 1'b1;
            writes   = 1'b1;
            to_reg   = dest_reg;
         end
         `OP_LIT_SUB: begin
            // Literal minus accumulator into accumulator
            next_res = diff[7:0];
            next_c   = diff[8];
            next_digit = ndiff[4];
            upd_c    = 1'b1;
            upd_digit = 1'b1;
            upd_z    = 1'b1;
            writes   = 1'b1;
         end
         `OP_REG_SUB: begin
            // Register minus accumulator
            next_res = diff[7:0];
            next_c   = diff[8];
            next_digit = ndiff[4];
            upd_c    = 1'b1;
            upd_digit = 1'b1;
            upd_z    = 1'b1;
            writes   = 1'b1;
            to_reg   = dest_reg;
         end
         `OP_REG_XOR: begin
            // Register XOR accumulator
            next_res = acc ^ fval;
            upd_z    = 1'b1;
            writes   = 1'b1;
            to_reg   = dest_reg;
         end
         `OP_LIT_XOR: begin
            // Literal XOR accumulator
            next_res = acc ^ literal;
            upd_z    = 1'b1;
            writes   = 1'b1;
         end
         `OP_NIB_SWAP: begin
            // Exchange nibbles, no flag touched
            next_res = {fval[3:0], fval[7:4]};
            writes   = 1'b1;
            to_reg   = dest_reg;
         end
         default: begin
            // Power-down and unknown codes write no result
            writes   = 1'b0;
         end
      endcase
   end

   // Execution state machine, registers and watchdog
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         state            <= S_IDLE;
         cmd              <= 32'h0000_0000;
         acc              <= `RST_ACC;
         carry_flag       <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero_flag        <= 1'b0;
         powerdown_flag_n <= `RST_FLAG_N;
         timeout_flag_n   <= `RST_FLAG_N;
         watchdog_counter <= `RST_WDOG;
         wdog_prescaler   <= {PRE_WIDTH{1'b0}};
      end else begin
         // Free-running watchdog
         wdog_prescaler <= wdog_prescaler + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
         if (wdog_tick) begin
            watchdog_counter <= watchdog_counter + 8'h01;
            // Overflow flags a time-out and wakes the core
            if (watchdog_counter == 8'hFF) begin
               timeout_flag_n <= 1'b0;
               if (state == S_SLEEP) begin
                  state <= S_IDLE;
               end
            end
         end
         case (state)
            S_IDLE: begin
               // Command write starts execution
               if (wr_go && !wr_file && I_AWADDR == `OFS_CMD) begin
                  cmd   <= I_WDATA;
                  state <= S_EXEC;
               end
            end
            S_EXEC: begin
               state <= S_IDLE;
               if (writes && !to_reg) begin
                  acc <= next_res;
               end
               if (upd_c) begin
                  carry_flag <= next_c;
               end
               if (upd_digit) begin
                  digit_carry_flag <= next_digit;
               end
               if (upd_z) begin
                  zero_flag <= (next_res == 8'h00);
               end
               if (op_code == `OP_POWERDOWN) begin
                  watchdog_counter <= 8'h00;
                  wdog_prescaler   <= {PRE_WIDTH{1'b0}};
                  powerdown_flag_n <= 1'b0;
                  timeout_flag_n   <= 1'b1;
                  state            <= S_SLEEP;
               end
            end
            S_SLEEP: begin
               // Commands are ignored until woken
               if (wr_go && !wr_file && I_AWADDR == `OFS_WAKE
                   && I_WSTRB[0] && I_WDATA[0]) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
         // Software writes to accumulator and arithmetic flags
         if (wr_go && !wr_file && I_AWADDR == `OFS_ACC
             && I_WSTRB[0]) begin
            acc <= I_WDATA[7:0];
         end
         if (wr_go && !wr_file && I_AWADDR == `OFS_STATUS
             && I_WSTRB[0]) begin
            carry_flag       <= I_WDATA[`ST_CARRY];
            digit_carry_flag <= I_WDATA[`ST_DIGIT];
            zero_flag        <= I_WDATA[`ST_ZERO];
         end
      end
   end

   // File registers: result write-back or bus write
   always @(posedge I_CORE_CLK) begin
      if (state == S_EXEC && writes && to_reg) begin
         file_reg[fadr] <= next_res;
      end else if (wr_go && wr_file && I_WSTRB[0]) begin
         file_reg[wr_idx] <= I_WDATA[7:0];
      end
   end

   // Write response channel
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_BVALID <= 1'b0;
         O_BRESP  <= `RESP_OKAY;
      end else if (wr_go) begin
         O_BVALID <= 1'b1;
         // Command, accumulator, status, wake and the file window answer okay
         if (wr_file) begin
            O_BRESP <= `RESP_OKAY;
         end else if (I_AWADDR == `OFS_CMD) begin
            O_BRESP <= `RESP_OKAY;
         end else if (I_AWADDR == `OFS_ACC) begin
            O_BRESP <= `RESP_OKAY;
         end else if (I_AWADDR == `OFS_STATUS) begin
            O_BRESP <= `RESP_OKAY;
         end else if (I_AWADDR == `OFS_WAKE) begin
            O_BRESP <= `RESP_OKAY;
         end else begin
            O_BRESP <= `RESP_SLVERR;
         end
      end else if (I_BREADY) begin
         O_BVALID <= 1'b0;
      end
   end

   // Read data channel
   always @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         O_RVALID <= 1'b0;
         O_RDATA  <= 32'h0000_0000;
         O_RRESP  <= `RESP_OKAY;
      end else if (rd_go) begin
         O_RVALID <= 1'b1;
         O_RRESP  <= `RESP_OKAY;
         O_RDATA  <= 32'h0000_0000;
         if (rd_file) begin
            O_RDATA <= {24'h000000, file_reg[rd_idx]};
         end else if (I_ARADDR == `OFS_CMD) begin
            O_RDATA <= cmd;
         end else if (I_ARADDR == `OFS_ACC) begin
            O_RDATA <= {24'h000000, acc};
         end else if (I_ARADDR == `OFS_STATUS) begin
            // State as seen by software
            O_RDATA <= {26'h0000000, (state == S_SLEEP),
                        timeout_flag_n, powerdown_flag_n,
                        zero_flag, digit_carry_flag, carry_flag};
         end else if (I_ARADDR == `OFS_WDOG) begin
            O_RDATA <= {{(24-PRE_WIDTH){1'b0}}, wdog_prescaler,
                        watchdog_counter};
         end else if (I_ARADDR == `OFS_WAKE) begin
            O_RDATA <= 32'h0000_0000;
         end else begin
            O_RRESP <= `RESP_SLVERR;
         end
      end else if (I_RREADY) begin
         O_RVALID <= 1'b0;
      end
   end

endmodule // alu_ops_core

// [test/alu_ops_core_asserts.sv]
/*
 Checker for alu_ops_core: bus answers, error responses and the
 power-down stop, watched from the top module's ports only.
 Assumes one clock, synchronous active-high reset, bound below.
*/
`timescale 1ns/1ps
`include "alu_ops_regs.vh"

module alu_ops_core_asserts (
   input wire        I_CORE_CLK,   // Core clock
   input wire        I_SYS_RST,    // Sync reset
   input wire [9:0]  I_AWADDR,     // Write address
   input wire        I_AWVALID,    // Write address valid
   input wire        O_AWREADY,    // Write address ready
   input wire [31:0] I_WDATA,      // Write data
   input wire        I_WVALID,     // Write data valid
   input wire [1:0]  O_BRESP,      // Write response
   input wire        O_BVALID,     // Write response valid
   input wire [9:0]  I_ARADDR,     // Read address
   input wire        I_ARVALID,    // Read address valid
   input wire        O_ARREADY,    // Read address ready
   input wire [31:0] O_RDATA,      // Read data
   input wire [1:0]  O_RRESP,      // Read response
   input wire        O_RVALID,     // Read data valid
   input wire        I_RREADY,     // Read data ready
   input wire        O_OSC_RUN     // Oscillator running
);
   // Write taken at this edge
   wire take  = I_AWVALID && I_WVALID && O_AWREADY;
   // Addresses in the unmapped gap
   wire gap_w = (I_AWADDR > `OFS_WAKE) && (I_AWADDR < `OFS_FILE_BASE);
   wire gap_r = (I_ARADDR > `OFS_WAKE) && (I_ARADDR < `OFS_FILE_BASE);
   // Command write that powers down an awake core
   wire sleep_go = take && (I_AWADDR == `OFS_CMD) && O_OSC_RUN
                && (I_WDATA[3:0] == `OP_POWERDOWN);

   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_SYS_RST);

   chk_wr_answer: assert property (take |=> O_BVALID)
      else $error("write not answered in the next cycle");
   chk_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
      else $error("read not answered in the next cycle");
   chk_rd_stands: assert property (O_RVALID && !I_RREADY
      |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
      else $error("read answer dropped before acceptance");
   chk_ar_ready: assert property (O_ARREADY == (I_ARVALID && !O_RVALID))
      else $error("read ready not valid while no read answer is pending");
   chk_gap_write: assert property (take && gap_w |=> O_BRESP == `RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_file_write: assert property (take && I_AWADDR >= `OFS_FILE_BASE
      |=> O_BRESP == `RESP_OKAY)
      else $error("file register write refused");
   chk_gap_read: assert property (I_ARVALID && O_ARREADY && gap_r
      |=> O_RRESP == `RESP_SLVERR && O_RDATA == 32'h0)
      else $error("unmapped read not refused with zero data");
   chk_cmd_stall: assert property (take && I_AWADDR == `OFS_CMD && O_OSC_RUN
      |=> !O_AWREADY)
      else $error("write taken during the execute cycle");
   chk_pd_stops: assert property (sleep_go |-> ##[1:3] !O_OSC_RUN)
      else $error("oscillator still running after power-down");
   chk_reset_osc: assert property ($fell(I_SYS_RST) |-> O_OSC_RUN)
      else $error("oscillator stopped after reset");
endmodule // alu_ops_core_asserts

bind alu_ops_core alu_ops_core_asserts u_chk (
   .I_CORE_CLK (I_CORE_CLK),
   .I_SYS_RST  (I_SYS_RST),
   .I_AWADDR   (I_AWADDR),
   .I_AWVALID  (I_AWVALID),
   .O_AWREADY  (O_AWREADY),
   .I_WDATA    (I_WDATA),
   .I_WVALID   (I_WVALID),
   .O_BRESP    (O_BRESP),
   .O_BVALID   (O_BVALID),
   .I_ARADDR   (I_ARADDR),
   .I_ARVALID  (I_ARVALID),
   .O_ARREADY  (O_ARREADY),
   .O_RDATA    (O_RDATA),
   .O_RRESP    (O_RRESP),
   .O_RVALID   (O_RVALID),
   .I_RREADY   (I_RREADY),
   .O_OSC_RUN  (O_OSC_RUN)
);

// [test/tb_alu_ops_core.sv]
/*
 Self-checking bench for alu_ops_core: a table of operations, then
 bus errors, power-down, wake and a second reset.
 Assumes the design header and the checker file are compiled first.
*/
`timescale 1ns/1ps
`include "alu_ops_regs.vh"

module tb_alu_ops_core;
   typedef struct packed {
      logic [3:0] op;  // Operation code
      logic       d;   // Destination select
      logic [6:0] f;   // File register address
      logic [7:0] k;   // Literal
      logic [7:0] a;   // Accumulator before
      logic [7:0] r;   // File register before
      logic [2:0] s;   // Z, DC, C before
      logic [7:0] e;   // Expected result
      logic [2:0] es;  // Expected Z, DC, C
   } row_t;

   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;  // Bench drives
   logic        awready, wready, bvalid, arready, rvalid, osc;       // Design drives
   logic [9:0]  awaddr, araddr;                                      // Addresses
   logic [31:0] wdata, rdata, rdat;                                  // Data words
   logic [3:0]  wstrb;                                               // Byte strobes
   logic [1:0]  bresp, rresp, wrsp, rrsp;                            // Responses
   row_t        rows [12];                                           // Case table
   row_t        rw;                                                  // Current row
   int          n_errors = 0;                                        // Mismatches
   int          checks = 0;                                          // Comparisons

   alu_ops_core u_dut (
      .I_CORE_CLK (clk), .I_SYS_RST (rst), .I_AWADDR (awaddr), .I_AWVALID (awvalid),
      .O_AWREADY (awready), .I_WDATA (wdata), .I_WSTRB (wstrb), .I_WVALID (wvalid),
      .O_WREADY (wready), .O_BRESP (bresp), .O_BVALID (bvalid), .I_BREADY (bready),
      .I_ARADDR (araddr), .I_ARVALID (arvalid), .O_ARREADY (arready), .O_RDATA (rdata),
      .O_RRESP (rresp), .O_RVALID (rvalid), .I_RREADY (rready), .O_OSC_RUN (osc)
   );

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Byte address of a file register
   function automatic logic [9:0] fa(input logic [6:0] f);
      return `OFS_FILE_BASE + {1'h0, f, 2'h0};
   endfunction

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus write, address and data offered together
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      @(negedge clk);
      while (awready !== 1'h1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk("wready", 32'h1, wready);
      @(posedge clk);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      @(negedge clk);
      while (bvalid !== 1'h1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      wrsp = bresp;
      @(posedge clk);
      bready <= 1'h0;
      if (n >= 200) n_errors++;
   endtask

   // One bus read; lag holds off read ready for that many cycles
   task automatic rd(input logic [9:0] a, input int lag = 0);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= (lag == 0);
      @(negedge clk);
      while (arready !== 1'h1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      arvalid <= 1'h0;
      @(negedge clk);
      while (rvalid !== 1'h1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (lag > 0) begin
         repeat (lag) @(posedge clk);
         rready <= 1'h1;
      end
      rdat = rdata;
      rrsp = rresp;
      @(posedge clk);
      rready <= 1'h0;
      if (n >= 200) n_errors++;
   endtask

   // Verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Cut a hung run short
   initial begin
      repeat (80000) @(posedge clk);
      n_errors++;
      results();
   end

   // Main sequence
   initial begin
      {clk, rst, awvalid, wvalid, bready, arvalid, rready} = 7'h20;
      {awaddr, araddr, wdata, wstrb} = 56'h0000000000000F;
      rows = '{
         '{4'h0, 1'h1, 7'h05, 8'h00, 8'h00, 8'h01, 3'h0, 8'h00, 3'h1},
         '{4'h0, 1'h0, 7'h7F, 8'h00, 8'h55, 8'h80, 3'h7, 8'hC0, 3'h6},
         '{4'h1, 1'h0, 7'h02, 8'h10, 8'h10, 8'h00, 3'h0, 8'h00, 3'h7},
         '{4'h1, 1'h0, 7'h02, 8'h00, 8'h01, 8'h00, 3'h7, 8'hFF, 3'h0},
         '{4'h2, 1'h1, 7'h03, 8'h00, 8'h17, 8'h35, 3'h4, 8'h1E, 3'h1},
         '{4'h2, 1'h0, 7'h00, 8'h00, 8'h20, 8'h10, 3'h1, 8'hF0, 3'h2},
         '{4'h3, 1'h1, 7'h40, 8'h00, 8'hA5, 8'hA5, 3'h3, 8'h00, 3'h7},
         '{4'h3, 1'h0, 7'h09, 8'h00, 8'hF0, 8'h0F, 3'h5, 8'hFF, 3'h1},
         '{4'h4, 1'h0, 7'h02, 8'hFF, 8'hFF, 8'h00, 3'h0, 8'h00, 3'h4},
         '{4'h4, 1'h0, 7'h02, 8'h3C, 8'h00, 8'h00, 3'h7, 8'h3C, 3'h3},
         '{4'h5, 1'h1, 7'h01, 8'h00, 8'h00, 8'h12, 3'h5, 8'h21, 3'h5},
         '{4'h5, 1'h0, 7'h7E, 8'h00, 8'h00, 8'hF0, 3'h2, 8'h0F, 3'h2}};
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd(`OFS_ACC);
      chk("reset acc", 32'h0, rdat[7:0]);
      rd(`OFS_STATUS);
      chk("reset status", 32'h18, rdat[5:0]);
      // Table of operations
      foreach (rows[i]) begin
         rw = rows[i];
         wr(`OFS_ACC, {24'h0, rw.a});
         wr(fa(rw.f), {24'h0, rw.r});
         wr(`OFS_STATUS, {29'h0, rw.s});
         wr(`OFS_CMD, {8'h00, rw.k, 1'h0, rw.f, 3'h0, rw.d, rw.op});
         rd(rw.d ? fa(rw.f) : `OFS_ACC);
         chk("result", rw.e, rdat[7:0]);
         rd(rw.d ? `OFS_ACC : fa(rw.f));
         chk("other place", rw.d ? rw.a : rw.r, rdat[7:0]);
         rd(`OFS_STATUS);
         chk("flags", {3'h3, rw.es}, rdat[5:0]);
      end
      // Unmapped place, slow read ready, read-only status bits
      wr(10'h014, 32'h1);
      chk("gap bresp", 32'h2, wrsp);
      rd(10'h014, 3);
      chk("gap rresp", 32'h2, rrsp);
      chk("gap rdata", 32'h0, rdat);
      wr(`OFS_STATUS, 32'h3D);
      rd(`OFS_STATUS);
      chk("ro status", 32'h1D, rdat[5:0]);
      // Power-down after the watchdog has counted
      repeat (300) @(posedge clk);
      rd(`OFS_WDOG);
      chk("wdog ran", 32'h1, rdat[7:0] != 8'h00);
      wr(`OFS_ACC, 32'h5A);
      wr(`OFS_CMD, {28'h0, `OP_POWERDOWN});
      rd(`OFS_WDOG);
      chk("wdog count", 32'h0, rdat[7:0]);
      chk("wdog prescale", 32'h1, rdat[15:8] < 8'h20);
      rd(`OFS_STATUS);
      chk("sleep status", 32'h35, rdat[5:0]);
      chk("osc asleep", 32'h0, osc);
      wr(`OFS_CMD, 32'h00FF0004);
      rd(`OFS_ACC);
      chk("asleep acc", 32'h5A, rdat[7:0]);
      wr(`OFS_WAKE, 32'h1);
      repeat (2) @(posedge clk);
      chk("osc woken", 32'h1, osc);
      // Second reset while asleep
      wr(`OFS_CMD, {28'h0, `OP_POWERDOWN});
      @(posedge clk);
      rst <= 1'h1;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd(`OFS_STATUS);
      chk("rerun status", 32'h18, rdat[5:0]);
      chk("rerun osc", 32'h1, osc);
      // Watchdog overflow wakes the sleeping core and flags a time-out
      wr(`OFS_CMD, {28'h0, `OP_POWERDOWN});
      repeat (65600) @(posedge clk);
      rd(`OFS_STATUS);
      chk("wake status", 32'h00, rdat[5:0]);
      chk("wake osc", 32'h1, osc);
      results();
   end
endmodule // tb_alu_ops_core
